// *** design/tfcc_cfg.svh ***
`ifndef TFCC_CFG_SVH
`define TFCC_CFG_SVH
`define TFCC_ADDR_W 8
`define TFCC_OFS_DIR 8'hc0
`define TFCC_OFS_FORCE 8'hc1
`define TFCC_OFS_MASK 8'hc2
`define TFCC_OFS_DATA 8'hc3
`define TFCC_OFS_CNT_HI 8'hc4
`define TFCC_OFS_CNT_LO 8'hc5
`define TFCC_OFS_SCR1 8'hc6
`define TFCC_OFS_ACT 8'he0
`define TFCC_OFS_CMP0 8'he1
`define TFCC_OFS_IRQ_STAT 8'he9
`define TFCC_OFS_IRQ_CLR 8'hea
`define TFCC_OFS_IRQ_EN 8'heb
`define TFCC_OFS_FLAGS 8'hec
`define TFCC_BIT_RUN 7
`define TFCC_BIT_FAST 4
`define TFCC_CNT_RESET 16'h0000
`define TFCC_CNT_MAX 16'hffff
`define TFCC_NUM_CMP 8'h04
`endif

// *** design/tfcc_pkg.sv ***
`default_nettype none
package tfcc_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
        logic word;
    } tfcc_bus_type;
    typedef struct packed {
        logic [3:0] dir;
        logic [3:0] mask;
        logic [3:0] data;
        logic [15:0] cnt;
        logic run;
        logic fast;
        logic [7:0] act;
        logic [3:0][15:0] cmp;
        logic [3:0] pinOut;
        logic [3:0] chFlag;
        logic ovfFlag;
        logic [4:0] irqStat;
        logic [4:0] irqEn;
        logic [15:0] rdata;
    } tfcc_state_type;
endpackage
`default_nettype wire

// *** design/tfcc_top.sv ***
// Overview of operation
// R1 - writing a one to a force bit performs that channel's compare action at once
// R2 - forced actions set no channel flag; the force register reads zero
// R3 - force and real match together: apply action, leave channel flag clear
// R4 - channel 3 compare wins over channels 0 to 2 on masked pins
// R5 - mask bit makes pin an output only while channel is output compare
// R6 - on channel 3 match, masked data bits are copied to pin outputs
// R7 - 16-bit up counter, reset zero, high byte at lower offset
// R8 - counter readable always, writable only in special mode
// R9 - counter write does not restart the prescaler tick
// R10 - software accesses the counter as one 16-bit word
// R11 - control register: run enable bit 7, fast clear bit 4, rest zero
// R12 - counter advances only while run enable is one
// R13 - fast clear: compare write clears channel flag, counter access clears overflow
// R14 - direction bit one means output compare, zero means input capture; no capture logic, zero only stops compare and pin drive
// R15 - counter increments on each tick, wraps to zero, signals overflow
`include "tfcc_cfg.svh"
`default_nettype none
module tfcc_top (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWordAccess,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdata,
    input wire logic prescaleTick,
    input wire logic specialMode,
    input wire logic [3:0] channelPinIn,
    output logic [3:0] channelPinOut,
    output logic [3:0] channelPinOen_n,
    output logic [3:0] compareMatch,
    output logic overflowPulse,
    output logic irq
);
    tfcc_pkg::tfcc_state_type st_q, st_d;
    tfcc_pkg::tfcc_bus_type bus;
    logic [3:0] match, force_, actFire, c3Take;
    logic wrap;

    assign bus = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd, word: regWordAccess};

    function automatic logic applyAct(input logic [1:0] a, input logic cur);
        case (a)
            2'b01: applyAct = ~cur;
            2'b10: applyAct = 1'b0;
            2'b11: applyAct = 1'b1;
            default: applyAct = cur;
        endcase
    endfunction

    always_comb begin
        st_d = st_q;
        force_ = '0;
        wrap = 1'b0;
        for (int i = 0; i < 4; i++) begin
            match[i] = st_q.dir[i] && st_q.run && prescaleTick && (st_q.cnt == st_q.cmp[i]);
        end
        if (bus.wr && bus.addr == `TFCC_OFS_FORCE) begin
            force_ = bus.wdata[3:0] & st_q.dir; // [R1] [R14]
        end
        actFire = match | force_; // [R1]
        c3Take = (actFire[3] ? st_q.mask : 4'h0) & st_q.dir; // [R4] [R14]
        for (int i = 0; i < 4; i++) begin
            if (c3Take[i]) begin
                st_d.pinOut[i] = st_q.data[i]; // [R6] [R4]
            end else if (actFire[i]) begin
                st_d.pinOut[i] = applyAct(st_q.act[2*i+:2], st_q.pinOut[i]);
            end
            if (match[i] && !force_[i]) begin
                st_d.chFlag[i] = 1'b1; // [R2] [R3]
            end
        end
        if (st_q.run && prescaleTick) begin
            st_d.cnt = st_q.cnt + 16'h0001; // [R12] [R15]
            wrap = (st_q.cnt == `TFCC_CNT_MAX); // [R15]
        end
        st_d.rdata = 16'h0000;
        if (bus.wr) begin
            if (bus.addr == `TFCC_OFS_DIR) begin
                st_d.dir = bus.wdata[3:0];
            end else if (bus.addr == `TFCC_OFS_MASK) begin
                st_d.mask = bus.wdata[3:0];
            end else if (bus.addr == `TFCC_OFS_DATA) begin
                st_d.data = bus.wdata[3:0];
            end else if (bus.addr == `TFCC_OFS_CNT_HI && specialMode) begin
                // [R8] [R9] [R10] prescaler untouched by this write
                st_d.cnt = bus.word ? bus.wdata : {bus.wdata[7:0], st_q.cnt[7:0]};
            end else if (bus.addr == `TFCC_OFS_CNT_LO && specialMode) begin
                st_d.cnt = {st_q.cnt[15:8], bus.wdata[7:0]}; // [R8]
            end else if (bus.addr == `TFCC_OFS_SCR1) begin
                st_d.run = bus.wdata[`TFCC_BIT_RUN]; // [R11]
                st_d.fast = bus.wdata[`TFCC_BIT_FAST]; // [R11]
            end else if (bus.addr == `TFCC_OFS_ACT) begin
                st_d.act = bus.wdata[7:0];
            end else if (bus.addr >= `TFCC_OFS_CMP0 && bus.addr < `TFCC_OFS_CMP0 + `TFCC_NUM_CMP) begin
                st_d.cmp[bus.addr[1:0] - 2'd1] = bus.wdata;
                if (st_q.fast && !match[bus.addr[1:0] - 2'd1]) begin
                    st_d.chFlag[bus.addr[1:0] - 2'd1] = 1'b0; // [R13]
                end
            end else if (bus.addr == `TFCC_OFS_IRQ_CLR) begin
                st_d.irqStat = st_q.irqStat & ~bus.wdata[4:0];
            end else if (bus.addr == `TFCC_OFS_IRQ_EN) begin
                st_d.irqEn = bus.wdata[4:0];
            end else if (bus.addr == `TFCC_OFS_FLAGS) begin
                st_d.chFlag = st_q.chFlag & ~bus.wdata[3:0] | (match & ~force_);
                st_d.ovfFlag = (st_q.ovfFlag & ~bus.wdata[4]) | wrap;
            end
        end
        if (bus.rd) begin
            if (bus.addr == `TFCC_OFS_DIR) begin
                st_d.rdata = {12'h000, st_q.dir};
            end else if (bus.addr == `TFCC_OFS_FORCE) begin
                st_d.rdata = 16'h0000; // [R2]
            end else if (bus.addr == `TFCC_OFS_MASK) begin
                st_d.rdata = {12'h000, st_q.mask};
            end else if (bus.addr == `TFCC_OFS_DATA) begin
                st_d.rdata = {12'h000, st_q.data};
            end else if (bus.addr == `TFCC_OFS_CNT_HI) begin
                st_d.rdata = bus.word ? st_q.cnt : {8'h00, st_q.cnt[15:8]}; // [R7] [R8]
            end else if (bus.addr == `TFCC_OFS_CNT_LO) begin
                st_d.rdata = {8'h00, st_q.cnt[7:0]};
            end else if (bus.addr == `TFCC_OFS_SCR1) begin
                st_d.rdata = {8'h00, st_q.run, 2'b00, st_q.fast, 4'h0}; // [R11]
            end else if (bus.addr == `TFCC_OFS_ACT) begin
                st_d.rdata = {8'h00, st_q.act};
            end else if (bus.addr == `TFCC_OFS_IRQ_STAT) begin
                st_d.rdata = {11'h000, st_q.irqStat};
            end else if (bus.addr == `TFCC_OFS_IRQ_EN) begin
                st_d.rdata = {11'h000, st_q.irqEn};
            end else if (bus.addr == `TFCC_OFS_FLAGS) begin
                st_d.rdata = {11'h000, st_q.ovfFlag, st_q.chFlag};
            end
        end
        if (wrap) begin
            st_d.ovfFlag = 1'b1; // [R15]
        end
        if (st_q.fast && !wrap && (bus.wr || bus.rd)
            && (bus.addr == `TFCC_OFS_CNT_HI || bus.addr == `TFCC_OFS_CNT_LO)) begin
            st_d.ovfFlag = 1'b0; // [R13]
        end
        st_d.irqStat = st_d.irqStat | {wrap, match & ~force_};
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= '0; // [R7] [R11]
        end else begin
            st_q <= st_d;
        end
    end

    assign regRdata = st_q.rdata;
    assign channelPinOut = st_q.pinOut;
    assign compareMatch = match;
    assign overflowPulse = wrap;
    assign irq = |(st_q.irqStat & st_q.irqEn);
    for (genvar g = 0; g < 4; g++) begin : g_oen
        // [R5] [R14] pin driven when action selected or masked by channel 3
        assign channelPinOen_n[g] = ~(st_q.dir[g] && (st_q.mask[g] || st_q.act[2*g+:2] != 2'b00));
    end

    cnt_reset_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R7]
        $rose(rstn) |-> st_q.cnt == `TFCC_CNT_RESET) else $error("count not zero");
    run_gate_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R12]
        !st_q.run && !(bus.wr && specialMode) |=> $stable(st_q.cnt)) else $error("count moved");
    count_inc_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R15]
        st_q.run && prescaleTick && !bus.wr |=> st_q.cnt == $past(st_q.cnt) + 16'h0001)
        else $error("count not incremented");
    force_noflag_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R2]
        force_[0] && !st_q.chFlag[0] && !bus.rd |=> !st_q.chFlag[0]) else $error("flag set");
    force_read_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R2]
        bus.rd && bus.addr == `TFCC_OFS_FORCE |=> regRdata == 16'h0000)
        else $error("force reads nonzero");
    c3_override_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R6]
        actFire[3] && st_q.mask[0] && st_q.dir[0] |=> channelPinOut[0] == $past(st_q.data[0]))
        else $error("override missed");
    normal_nowr_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R8]
        !specialMode && !st_q.run && bus.wr |=> $stable(st_q.cnt)) else $error("write taken");
    oen_mode_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R5]
        !st_q.dir[2] |-> channelPinOen_n[2]) else $error("capture pin driven");
    wrap_ovf_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R15]
        st_q.run && prescaleTick && st_q.cnt == `TFCC_CNT_MAX && !bus.wr
        |=> st_q.cnt == `TFCC_CNT_RESET && st_q.ovfFlag) else $error("wrap lost");
    force_set_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R1]
        force_[0] && !c3Take[0] && st_q.act[1:0] == 2'b11 |=> channelPinOut[0])
        else $error("forced set missed");
    force_toggle_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R1]
        force_[0] && !c3Take[0] && st_q.act[1:0] == 2'b01
        |=> channelPinOut[0] != $past(channelPinOut[0])) else $error("forced toggle missed");
    force_capture_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R14]
        bus.wr && bus.addr == `TFCC_OFS_FORCE && !st_q.dir[0]
        |=> $stable(channelPinOut[0])) else $error("capture pin forced");
    c3_prio_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R4]
        actFire[3] && actFire[0] && st_q.mask[0] && st_q.dir[0] && st_q.act[1:0] != 2'b00
        |=> channelPinOut[0] == $past(st_q.data[0])) else $error("channel 3 lost priority");
    oen_mask_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R5]
        st_q.dir[0] && st_q.mask[0] |-> !channelPinOen_n[0]) else $error("masked pin not driven");
    collide_flag_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R3]
        match[0] && force_[0] && !st_q.chFlag[0] |=> !st_q.chFlag[0])
        else $error("flag set on forced match");
    match_flag_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R3]
        match[0] && !force_[0] |=> st_q.chFlag[0]) else $error("match flag lost");
    fast_cmp_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R13]
        st_q.fast && bus.wr && bus.addr == `TFCC_OFS_CMP0 && !match[0] |=> !st_q.chFlag[0])
        else $error("fast clear missed");
    fast_ovf_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R13]
        st_q.fast && !wrap && bus.rd && bus.addr == `TFCC_OFS_CNT_HI |=> !st_q.ovfFlag)
        else $error("overflow not cleared");
    scr1_read_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R11]
        bus.rd && bus.addr == `TFCC_OFS_SCR1 |=> regRdata[15:8] == 8'h00
        && regRdata[6:5] == 2'b00 && regRdata[3:0] == 4'h0) else $error("control bits leak");
    cnt_read_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R7]
        bus.rd && bus.word && bus.addr == `TFCC_OFS_CNT_HI |=> regRdata == $past(st_q.cnt))
        else $error("count read wrong");
    special_wr_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R8]
        specialMode && bus.wr && bus.word && bus.addr == `TFCC_OFS_CNT_HI
        |=> st_q.cnt == $past(bus.wdata)) else $error("count write lost");
    cov_force_c: cover property (@(posedge sys_clk) disable iff (!rstn) |force_);
    cov_wrap_c: cover property (@(posedge sys_clk) disable iff (!rstn) wrap);
    cov_c3_c: cover property (@(posedge sys_clk) disable iff (!rstn) |c3Take);
    cov_toggle_c: cover property (@(posedge sys_clk) disable iff (!rstn)
        force_[0] && st_q.act[1:0] == 2'b01);
    cov_collide_c: cover property (@(posedge sys_clk) disable iff (!rstn) |(match & force_));
endmodule // tfcc_top
`default_nettype wire

// *** dv/tfcc_mcu_model.sv ***
`default_nettype none
module tfcc_mcu_model (
    input wire logic sys_clk,
    output logic [7:0] regAddr,
    output logic [15:0] regWdata,
    output logic regWordAccess,
    output logic regWr,
    output logic regRd
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        regAddr = 8'h00;
        regWdata = 16'h0000;
        regWordAccess = 1'b0;
        regWr = 1'b0;
        regRd = 1'b0;
    end
    // one-cycle strobe; address and data lines then show the inverse of their last value, strobes drop to zero
    task automatic access(input logic [7:0] a, input logic [15:0] d, input logic w,
                          input logic r);
        regAddr <= a;
        regWdata <= d;
        regWordAccess <= w; // counter moved as one word
        regWr <= !r;
        regRd <= r;
        @(posedge sys_clk);
        regWr <= 1'b0;
        regRd <= 1'b0;
        regAddr <= ~a;
        regWdata <= ~d;
        @(posedge sys_clk);
    endtask
endmodule // tfcc_mcu_model
`default_nettype wire

// *** dv/testbench.sv ***
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic prescaleTick = 1'b0;
    logic specialMode = 1'b0;
    logic rdPend = 1'b0;
    logic [7:0] regAddr;
    logic [15:0] regWdata, regRdata, cval;
    logic regWordAccess, regWr, regRd, ovf, irq;
    logic [3:0] pinOut, pinOen_n, match;
    logic [15:0] expQ[$];
    int n_errors = 0;
    int checks_done = 0;
    int n;
    always #10 sys_clk = ~sys_clk;
    tfcc_mcu_model mcu (.sys_clk(sys_clk), .regAddr(regAddr), .regWdata(regWdata),
        .regWordAccess(regWordAccess), .regWr(regWr), .regRd(regRd));
    tfcc_top dut (.sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
        .regWordAccess(regWordAccess), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .prescaleTick(prescaleTick), .specialMode(specialMode), .channelPinIn(4'h0),
        .channelPinOut(pinOut), .channelPinOen_n(pinOen_n), .compareMatch(match),
        .overflowPulse(ovf), .irq(irq));
    task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic w = 1'b0);
        mcu.access(a, d, w, 1'b0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic w = 1'b0);
        expQ.push_back(e);
        mcu.access(a, 16'h0000, w, 1'b1);
    endtask
    task automatic pins(input logic [3:0] eo, input logic [3:0] en, input logic ei);
        @(negedge sys_clk);
        cmp("channelPinOut", {12'h000, eo}, {12'h000, pinOut});
        cmp("channelPinOen_n", {12'h000, en}, {12'h000, pinOen_n});
        cmp("irq", {15'h0000, ei}, {15'h0000, irq});
        @(posedge sys_clk);
    endtask
    task automatic tick(input int k);
        repeat (k) begin
            prescaleTick <= 1'b1;
            @(posedge sys_clk);
            prescaleTick <= 1'b0;
            @(posedge sys_clk);
        end
    endtask
    task automatic wrap_up();
        if (expQ.size() != 0) n_errors++;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // read data stand only in the cycle after the strobe
    always @(posedge sys_clk) rdPend <= regRd;
    always @(negedge sys_clk) begin
        if (rdPend === 1'b1) begin
            if (expQ.size() == 0) n_errors++;
            else cmp("regRdata", expQ.pop_front(), regRdata);
        end
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        wrap_up();
    end
    initial begin
        void'($urandom(48));
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        rd(8'hc6, 16'h0000);
        rd(8'hc1, 16'h0000);
        rd(8'hc4, 16'h0000, 1'b1);
        wr(8'hc6, 16'h00ff);
        rd(8'hc6, 16'h0090);
        n = 1 + $urandom % 20;
        tick(n);
        rd(8'hc4, n[15:0], 1'b1);
        wr(8'hc6, 16'h0000);
        tick(3);
        rd(8'hc4, n[15:0], 1'b1);
        $display("test counter done");
        cval = 16'($urandom);
        wr(8'hc4, cval, 1'b1);
        rd(8'hc4, n[15:0], 1'b1);
        specialMode <= 1'b1;
        wr(8'hc4, cval, 1'b1);
        rd(8'hc4, {8'h00, cval[15:8]});
        rd(8'hc5, {8'h00, cval[7:0]});
        wr(8'hc4, 16'hffff, 1'b1);
        wr(8'hc6, 16'h0080);
        prescaleTick <= 1'b1;
        @(negedge sys_clk);
        cmp("overflowPulse", 16'h0001, {15'h0000, ovf});
        @(posedge sys_clk);
        prescaleTick <= 1'b0;
        wr(8'hc6, 16'h0000);
        rd(8'hc4, 16'h0000, 1'b1);
        $display("test counter write done");
        wr(8'hea, 16'h001f);
        wr(8'heb, 16'h001f);
        wr(8'hc0, 16'h0009);
        wr(8'he0, 16'h0001);
        wr(8'hc1, 16'h0001);
        pins(4'h1, 4'he, 1'b0);
        wr(8'he0, 16'h0002);
        wr(8'hc1, 16'h0001);
        pins(4'h0, 4'he, 1'b0);
        wr(8'he0, 16'h0003);
        wr(8'hc1, 16'h0001);
        pins(4'h1, 4'he, 1'b0);
        rd(8'he9, 16'h0000);
        rd(8'hc1, 16'h0000);
        wr(8'hc2, 16'h0001);
        wr(8'hc3, 16'h0000);
        wr(8'hc1, 16'h0009);
        pins(4'h0, 4'he, 1'b0);
        wr(8'he0, 16'h0000);
        pins(4'h0, 4'he, 1'b0);
        wr(8'hc0, 16'h0008);
        wr(8'hc1, 16'h000f);
        pins(4'h0, 4'hf, 1'b0);
        $display("test force and override done");
        wr(8'hc0, 16'h0001);
        wr(8'he1, 16'h0002, 1'b1);
        wr(8'hc6, 16'h0080);
        tick(3);
        pins(4'h0, 4'he, 1'b1);
        rd(8'he9, 16'h0001);
        rd(8'hec, 16'h0011);
        wr(8'heb, 16'h0000);
        pins(4'h0, 4'he, 1'b0);
        wr(8'hea, 16'h0001);
        rd(8'he9, 16'h0000);
        wr(8'hc6, 16'h0090);
        wr(8'he1, 16'h0002, 1'b1);
        rd(8'hc4, 16'h0003, 1'b1);
        rd(8'hec, 16'h0000);
        rd(8'hf0, 16'h0000);
        wr(8'he1, 16'h0003, 1'b1);
        prescaleTick <= 1'b1;
        fork
            wr(8'hc1, 16'h0001);
            begin
                @(negedge sys_clk);
                cmp("compareMatch", 16'h0001, {12'h000, match});
                @(posedge sys_clk);
                prescaleTick <= 1'b0;
            end
        join
        rd(8'hec, 16'h0000);
        rd(8'he9, 16'h0000);
        rd(8'hc4, 16'h0004, 1'b1);
        $display("test interrupts done");
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        rd(8'hc6, 16'h0000);
        rd(8'hc4, 16'h0000, 1'b1);
        pins(4'h0, 4'hf, 1'b0);
        $display("test reset done");
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
